// File: design/ldo_regulator_control_regs.sv
// Purpose: APB register bank for three linear regulators
// Assumes: Power-good and fault inputs already synchronous to clk_sys
// Notes:   Zero wait states; unmapped addresses raise pslverr
//
// How it works
// [R1] Each level register holds a 6-bit writable code in bits 5:0, bits 7:6 read-only.
// [R2] Control bit 7 is a writable enable that turns the regulator on or off.
// [R3] Control bit 2 discharges the output while the regulator is shut down.
// [R4] Control bit 1 lets that regulator's faults raise interrupts when set.
// [R5] Control bit 0 reads power-good status and ignores writes.
// [R6] Control bits 6:3 are reserved and read-only.
// [R7] Reserved bits read zero and writes to them never disturb other fields.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "ldo_regs_defs.svh"

module ldo_regulator_control_regs
    import ldo_regs_pkg::*;
#(
    parameter int NUM_LDO = 3
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // APB slave
    input  wire apb_req_t              apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Regulator analog side
    input  wire logic [NUM_LDO-1:0]    power_good,
    input  wire logic [NUM_LDO-1:0]    ldo_fault,
    output logic [NUM_LDO-1:0]         ldo_enable,
    output logic [NUM_LDO-1:0]         discharge_on,
    output logic [NUM_LDO*6-1:0]       output_level_code,
    // Interrupt
    output logic                       irq
);

    // Register map has room for exactly three regulators
    if (NUM_LDO != 3) begin : g_bad_count
        $error("NUM_LDO must be 3 to match the register map");
    end

    // One clock domain, so every check shares one clock and reset
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    ldo_ctrl_t                 ctrl [NUM_LDO];
    logic [5:0]                irq_status;
    logic [5:0]                irq_mask;
    logic [9:0]                word_idx;
    logic                      access;
    logic                      wr_en;
    logic [NUM_LDO-1:0]        hit_level;
    logic [NUM_LDO-1:0]        hit_ctrl;
    logic                      hit_status;
    logic                      hit_mask;
    logic                      mapped;
    logic [NUM_LDO-1:0]        pg_prev;
    logic [5:0]                event_in;

    assign word_idx   = apb_req.paddr[11:2];
    assign access     = apb_req.psel && apb_req.penable;
    assign hit_level  = {word_idx == 10'(`LDO_C_LEVEL_IDX),
                         word_idx == 10'(`LDO_B_LEVEL_IDX),
                         word_idx == 10'(`LDO_A_LEVEL_IDX)};
    assign hit_ctrl   = {word_idx == 10'(`LDO_C_CONTROL_IDX),
                         word_idx == 10'(`LDO_B_CONTROL_IDX),
                         word_idx == 10'(`LDO_A_CONTROL_IDX)};
    assign hit_status = word_idx == 10'(`IRQ_STATUS_IDX);
    assign hit_mask   = word_idx == 10'(`IRQ_MASK_IDX);
    assign mapped     = (|hit_level) || (|hit_ctrl) || hit_status || hit_mask;
    assign wr_en      = access && apb_req.pwrite && mapped;

    // Unmapped words answer with pslverr and read as zero
    // Always ready: no register needs more than one access cycle
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // Regulator fields

    for (genvar i = 0; i < NUM_LDO; i++) begin : g_ldo
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                ctrl[i] <= '0;
            end else begin
                if (wr_en && hit_level[i])
                    ctrl[i].output_level_code <=
                        apb_req.pwdata[`LEVEL_MSB:0]; // R1 R7
                if (wr_en && hit_ctrl[i]) begin
                    ctrl[i].enable <=
                        apb_req.pwdata[`CTRL_ENABLE_BIT]; // R2
                    ctrl[i].shutdown_discharge_enable <=
                        apb_req.pwdata[`CTRL_DISCH_BIT]; // R3
                    ctrl[i].fault_irq_enable <=
                        apb_req.pwdata[`CTRL_FLTEN_BIT]; // R4
                end
            end
        end

        assign ldo_enable[i]   = ctrl[i].enable;
        // Discharge only while off, never fights a live output
        assign discharge_on[i] = ctrl[i].shutdown_discharge_enable
                                 && !ctrl[i].enable; // R3
        assign output_level_code[i*6 +: 6] = ctrl[i].output_level_code;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: bits 2:0 fault, bits 5:3 power-good loss

    // Reset low, so a regulator that is off never shows a false loss
    always_ff @(posedge clk_sys) begin
        if (rst)
            pg_prev <= '0;
        else
            pg_prev <= power_good;
    end

    always_comb begin
        event_in = 6'h00;
        for (int k = 0; k < NUM_LDO; k++) begin
            event_in[k]     = ldo_fault[k] && ctrl[k].fault_irq_enable; // R4
            event_in[k + 3] = pg_prev[k] && !power_good[k];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst)
            irq_status <= 6'h00;
        else if (wr_en && hit_status)
            irq_status <= (irq_status & ~apb_req.pwdata[5:0]) | event_in;
        else
            irq_status <= irq_status | event_in;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            irq_mask <= `IRQ_MASK_RESET;
        else if (wr_en && hit_mask)
            irq_mask <= apb_req.pwdata[5:0];
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // Read data, registered on the setup edge

    // Latched at the setup edge so the access phase needs no wait state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            prdata <= 32'h0000_0000; // R7
            for (int k = 0; k < NUM_LDO; k++) begin
                if (hit_level[k])
                    prdata[5:0] <= ctrl[k].output_level_code; // R1
                if (hit_ctrl[k])
                    prdata[7:0] <= {ctrl[k].enable, 4'h0, // R6
                                    ctrl[k].shutdown_discharge_enable,
                                    ctrl[k].fault_irq_enable,
                                    power_good[k]}; // R5
            end
            if (hit_status)
                prdata[5:0] <= irq_status;
            if (hit_mask)
                prdata[5:0] <= irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    // Write checks look one clock after the access edge
    chk_level_write: assert property ( // R1
        wr_en && hit_level[0] |=>
        ctrl[0].output_level_code == $past(apb_req.pwdata[5:0]))
        else $error("level code not stored");

    chk_level_b_write: assert property ( // R1
        wr_en && hit_level[1] |=>
        ctrl[1].output_level_code == $past(apb_req.pwdata[5:0]))
        else $error("level code B not stored");

    chk_level_c_write: assert property ( // R1
        wr_en && hit_level[2] |=>
        ctrl[2].output_level_code == $past(apb_req.pwdata[5:0]))
        else $error("level code C not stored");

    chk_level_read: assert property ( // R1
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_level[1]
        |=> prdata[5:0] == $past(ctrl[1].output_level_code))
        else $error("level code readback wrong");

    chk_enable_write: assert property ( // R2
        wr_en && hit_ctrl[1] |=>
        ldo_enable[1] == $past(apb_req.pwdata[7]))
        else $error("enable bit not stored");

    chk_enable_a_write: assert property ( // R2
        wr_en && hit_ctrl[0] |=>
        ldo_enable[0] == $past(apb_req.pwdata[7]))
        else $error("enable bit A not stored");

    chk_enable_hold: assert property ( // R2
        !ldo_enable[0] && !(wr_en && hit_ctrl[0]) |=> !ldo_enable[0])
        else $error("enable rose without a write");

    chk_enable_read: assert property ( // R2
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl[2]
        |=> prdata[7] == $past(ctrl[2].enable))
        else $error("enable readback wrong");

    chk_discharge_off: assert property ( // R3
        discharge_on[2] |-> !ldo_enable[2]
        && ctrl[2].shutdown_discharge_enable)
        else $error("discharge while regulator on");

    chk_discharge_write: assert property ( // R3
        wr_en && hit_ctrl[0] |=>
        ctrl[0].shutdown_discharge_enable == $past(apb_req.pwdata[2]))
        else $error("discharge bit not stored");

    chk_discharge_shutdown: assert property ( // R3
        ctrl[1].shutdown_discharge_enable && !ldo_enable[1]
        |-> discharge_on[1])
        else $error("no discharge in shutdown");

    chk_fault_en_write: assert property ( // R4
        wr_en && hit_ctrl[2] |=>
        ctrl[2].fault_irq_enable == $past(apb_req.pwdata[1]))
        else $error("fault enable bit not stored");

    chk_fault_en_hold: assert property ( // R4
        !ctrl[1].fault_irq_enable && !(wr_en && hit_ctrl[1])
        |=> !ctrl[1].fault_irq_enable)
        else $error("fault enable rose without a write");

    chk_fault_masked: assert property ( // R4
        !ctrl[0].fault_irq_enable && !irq_status[0] && !access
        |=> !irq_status[0])
        else $error("masked fault raised status");

    chk_fault_raises: assert property ( // R4
        ldo_fault[0] && ctrl[0].fault_irq_enable |=> irq_status[0])
        else $error("enabled fault did not set status");

    chk_status_sticky: assert property ( // R4
        irq_status[0] && !(wr_en && hit_status) |=> irq_status[0])
        else $error("fault status cleared without a write");

    chk_pgood_read: assert property ( // R5
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl[0]
        |=> prdata[0] == $past(power_good[0]))
        else $error("power-good readback wrong");

    chk_pgood_b_read: assert property ( // R5
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl[1]
        |=> prdata[0] == $past(power_good[1]))
        else $error("power-good B readback wrong");

    chk_pgood_c_read: assert property ( // R5
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && hit_ctrl[2]
        |=> prdata[0] == $past(power_good[2]))
        else $error("power-good C readback wrong");

    chk_reserved_zero: assert property ( // R6
        $past(apb_req.psel && !apb_req.penable && !apb_req.pwrite
              && (|hit_ctrl))
        |-> prdata[6:3] == 4'h0 && prdata[31:8] == 24'h0)
        else $error("reserved control bits not zero");

    chk_level_rsvd: assert property ( // R7
        $past(apb_req.psel && !apb_req.penable && !apb_req.pwrite
              && (|hit_level))
        |-> prdata[31:6] == 26'h0)
        else $error("reserved level bits not zero");

    chk_ctrl_keeps_level: assert property ( // R7
        wr_en && hit_ctrl[0] |=> $stable(ctrl[0].output_level_code))
        else $error("control write disturbed level");

    chk_level_keeps_ctrl: assert property ( // R7
        wr_en && hit_level[1] |=> $stable(ctrl[1].enable)
        && $stable(ctrl[1].shutdown_discharge_enable)
        && $stable(ctrl[1].fault_irq_enable))
        else $error("level write disturbed control");

    chk_unmapped_ignored: assert property ( // R7
        access && apb_req.pwrite && !mapped |=> $stable(ctrl[0])
        && $stable(ctrl[1]) && $stable(ctrl[2]) && $stable(irq_mask))
        else $error("unmapped write changed a register");

    // Main scenarios
    cov_level_write: cover property (@(posedge clk_sys) wr_en && hit_level[2]);
    cov_irq_raise:   cover property (@(posedge clk_sys) $rose(irq));
    cov_unmapped:    cover property (@(posedge clk_sys) pslverr);
    cov_pgood_loss:  cover property (@(posedge clk_sys) |event_in[5:3]);
    cov_set_wins:    cover property (@(posedge clk_sys)
        wr_en && hit_status && (|(event_in & apb_req.pwdata[5:0])));

endmodule : ldo_regulator_control_regs

// File: design/ldo_regs_defs.svh
// Purpose: Offsets, field positions and reset values of the regulator bank
// Assumes: Byte addresses are four times the printed register index
// Notes:   Definitions only
`ifndef LDO_REGS_DEFS_SVH
`define LDO_REGS_DEFS_SVH

// Printed register indices
`define LDO_A_LEVEL_IDX   8'h50
`define LDO_A_CONTROL_IDX 8'h51
`define LDO_B_LEVEL_IDX   8'h58
`define LDO_B_CONTROL_IDX 8'h59
`define LDO_C_LEVEL_IDX   8'h60
`define LDO_C_CONTROL_IDX 8'h61
// Interrupt status and mask, index chosen here
`define IRQ_STATUS_IDX    8'h70
`define IRQ_MASK_IDX      8'h71

// Field positions
`define LEVEL_MSB        5
`define CTRL_ENABLE_BIT  7
`define CTRL_DISCH_BIT   2
`define CTRL_FLTEN_BIT   1
`define CTRL_PGOOD_BIT   0

// Reset values
`define LEVEL_RESET      6'h00
`define IRQ_MASK_RESET   6'h00

`endif

// File: design/ldo_regs_pkg.sv
// Purpose: Types shared by the regulator register bank
// Assumes: Three regulators
// Notes:   Constants live in ldo_regs_defs.svh
package ldo_regs_pkg;

    typedef struct packed {
        logic       enable;
        logic       shutdown_discharge_enable;
        logic       fault_irq_enable;
        logic [5:0] output_level_code;
    } ldo_ctrl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : ldo_regs_pkg

// File: verif/ldo_regulator_control_regs_test.sv
// Purpose: Self-checking bench for the regulator register bank
// Assumes: Zero-wait APB slave, byte address is four times the index
// Notes:   Bench drives every input directly, no partner model
`timescale 1ns/1ps
`include "ldo_regs_defs.svh"
module ldo_regulator_control_regs_test
    import ldo_regs_pkg::*;
;
logic        clk_sys, rst, irq, pready, pslverr, err;
apb_req_t    req;
logic [31:0] prdata, rd;
logic [2:0]  power_good, ldo_fault, ldo_enable, discharge_on;
logic [17:0] level;
int          error_cnt, num_checks, cyc;
logic [7:0]  lvl [3] = '{`LDO_A_LEVEL_IDX, `LDO_B_LEVEL_IDX, `LDO_C_LEVEL_IDX};
logic [7:0]  ctl [3] = '{`LDO_A_CONTROL_IDX, `LDO_B_CONTROL_IDX,
                         `LDO_C_CONTROL_IDX};
////////////////////////////////////////////////////////////////////////////
initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
end
ldo_regulator_control_regs i_dut (.clk_sys(clk_sys), .rst(rst),
    .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_good(power_good), .ldo_fault(ldo_fault), .ldo_enable(ldo_enable),
    .discharge_on(discharge_on), .output_level_code(level), .irq(irq));
////////////////////////////////////////////////////////////////////////////
task automatic chk(input string what, input logic [31:0] exp, got);
    num_checks++;
    if (got !== exp) begin
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
endtask : chk
// Ends with an idle edge so the next request never lands in the same step
task automatic xfer(input logic wr, input logic [7:0] idx,
                    input logic [31:0] wd);
    req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, wd};
    @(posedge clk_sys) req.penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_sys);
endtask : xfer
task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk($sformatf("reg %h", idx), exp, rd);
endtask : rdchk
task automatic outchk(input string what, input logic [31:0] exp);
    @(negedge clk_sys);
    case (what)
        "irq": chk(what, exp, 32'(irq));
        "en":  chk(what, exp, 32'(ldo_enable));
        "dis": chk(what, exp, 32'(discharge_on));
        default: chk(what, exp, 32'(level));
    endcase
    @(posedge clk_sys);
endtask : outchk
////////////////////////////////////////////////////////////////////////////
task automatic test_level;
    for (int i = 0; i < 3; i++) begin
        xfer(1'b1, lvl[i], 32'hFFFF_FFFF);
        rdchk(lvl[i], 32'h3F);
    end
    outchk("lvl", 32'h3_FFFF);
    for (int i = 0; i < 3; i++) begin
        xfer(1'b1, lvl[i], 32'hD5);
        rdchk(lvl[i], 32'h15);
    end
    outchk("lvl", 32'({3{6'h15}}));
endtask : test_level
task automatic test_control;
    power_good <= 3'b101;
    for (int i = 0; i < 3; i++) begin
        xfer(1'b1, ctl[i], 32'hFF);
        rdchk(ctl[i], 32'h86 | power_good[i]);
    end
    outchk("en", 32'h7);
    outchk("dis", 32'h0);
    for (int i = 0; i < 3; i++) begin
        xfer(1'b1, ctl[i], 32'h04);
        rdchk(ctl[i], 32'h04 | power_good[i]);
    end
    outchk("en", 32'h0);
    outchk("dis", 32'h7);
endtask : test_control
// Fault on A: raised, masked, cleared, then suppressed by its enable bit
task automatic test_irq;
    xfer(1'b1, ctl[0], 32'h02);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h01);
    ldo_fault <= 3'b001;
    repeat (2) @(posedge clk_sys);
    outchk("irq", 32'h1);
    rdchk(`IRQ_STATUS_IDX, 32'h01);
    // Clear while the fault is held: the set wins
    xfer(1'b1, `IRQ_STATUS_IDX, 32'h01);
    rdchk(`IRQ_STATUS_IDX, 32'h01);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h00);
    outchk("irq", 32'h0);
    ldo_fault <= 3'b000;
    xfer(1'b1, `IRQ_STATUS_IDX, 32'h3F);
    xfer(1'b1, `IRQ_MASK_IDX, 32'h3F);
    outchk("irq", 32'h0);
    xfer(1'b1, ctl[0], 32'h00);
    ldo_fault <= 3'b001;
    repeat (2) @(posedge clk_sys);
    outchk("irq", 32'h0);
endtask : test_irq
task automatic test_unmapped;
    xfer(1'b1, 8'h52, 32'hFF);
    chk("wr err", 32'h1, 32'(err));
    xfer(1'b0, 8'h52, 32'h0);
    chk("rd err", 32'h1, 32'(err));
    chk("rd data", 32'h0, rd);
    rdchk(lvl[1], 32'h15);
endtask : test_unmapped
// Power-good loss on C sets its sticky bit and raises irq
task automatic test_pgood;
    power_good <= 3'b001;
    repeat (2) @(posedge clk_sys);
    rdchk(ctl[2], 32'h04);
    rdchk(`IRQ_STATUS_IDX, 32'h20);
    outchk("irq", 32'h1);
    xfer(1'b1, `IRQ_STATUS_IDX, 32'h20);
    outchk("irq", 32'h0);
endtask : test_pgood
// Reset pulse in mid-run brings every writable field back to zero
task automatic test_reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
        rdchk(lvl[i], 32'h0);
        rdchk(ctl[i], 32'(power_good[i]));
    end
    rdchk(`IRQ_MASK_IDX, 32'h0);
    outchk("en", 32'h0);
    outchk("irq", 32'h0);
endtask : test_reset
////////////////////////////////////////////////////////////////////////////
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask : tally_and_finish
always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
        error_cnt++;
        tally_and_finish();
    end
end
initial begin
    rst <= 1'b1;
    req <= '0;
    power_good <= 3'b000;
    ldo_fault <= 3'b000;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rdchk(ctl[i], 32'h0);
    test_level();
    test_control();
    test_irq();
    test_unmapped();
    test_pgood();
    test_reset();
    tally_and_finish();
end
endmodule : ldo_regulator_control_regs_test
